// ===== design/vec_unit_regs.svh
`ifndef VEC_UNIT_REGS_SVH
`define VEC_UNIT_REGS_SVH

// ==========================================================================
// Command word layout
`define EXECUTE_FORM_PREFIX_PREFIX 5'h10
`define PREFIX_MSB 15
`define PREFIX_LSB 11

// ==========================================================================
// Function codes
`define FN_COPY_REAL 11'h52B
`define FN_COPY_PAIRED 11'h438
`define FN_INT_GATHER 11'h43A
`define FN_INT_SCATTER 11'h440
`define FN_EXT_LOAD 11'h44F
`define FN_EXT_STORE 11'h455
`define FN_EXT_GATHER 11'h446
`define FN_ELEM_OP 11'h568
`define FN_PAIRED_OP 11'h41A
`define FN_REAL_ACC 11'h407
`define FN_CPLX_ACC 11'h475
`define FN_REAL_LAT 11'h42C
`define FN_CPLX_LAT 11'h4E8
`define FN_INT_MULADD 11'h414

// ==========================================================================
// Operation select codes
`define OP_ADD 6'h1A
`define OP_SUB 6'h27
`define OP_AND_NOT 6'h08
`define OP_AND 6'h20
`define OP_OR 6'h38
`define OP_XOR 6'h18
`define OP_COMPLEMENT 6'h0C

// ==========================================================================
// Accumulator to real result slice, address mask
`define FRAC_MSB 30
`define FRAC_LSB 15
`define ADDR_MASK 16'hFFFF

`endif

// ===== design/vec_unit_pkg.sv
package vec_unit_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_RX = 4'b0001, ST_RY = 4'b0010, ST_RZ = 4'b0011,
    ST_RI = 4'b0100, ST_LAT = 4'b0101, ST_EXT = 4'b0110, ST_ACC = 4'b0111,
    ST_WR = 4'b1000, ST_DONE = 4'b1001
  } state_e;

  typedef enum logic [3:0] {
    K_COPY = 4'b0000, K_PCOPY = 4'b0001, K_GATH = 4'b0010, K_SCAT = 4'b0011,
    K_XLD = 4'b0100, K_XST = 4'b0101, K_XGA = 4'b0110, K_OP = 4'b0111,
    K_POP = 4'b1000, K_RMAC = 4'b1001, K_PMAC = 4'b1010, K_CMAC = 4'b1011,
    K_RLAT = 4'b1100, K_CLAT = 4'b1101, K_IMAD = 4'b1110, K_NONE = 4'b1111
  } kind_e;

  typedef struct packed {
    state_e st;
    kind_e kind;
    logic [15:0] n;
    logic [15:0] cnt;
    logic [15:0] xa;
    logic [15:0] ya;
    logic [15:0] za;
    logic [23:0] base;
    logic [5:0] op;
    logic clr;
    logic sub;
    logic conj;
    logic ind;
    logic seed;
    logic fin;
    logic [31:0] xd;
    logic [31:0] yd;
    logic [31:0] zd;
    logic [31:0] acc_re;
    logic [31:0] acc_im;
    logic rd_pend;
    logic [1:0] rd_tgt;
    logic [15:0] ram_addr;
    logic ram_rd;
    logic ram_wr;
    logic [1:0] ram_wen;
    logic [31:0] ram_wdata;
    logic ext_req;
    logic ext_we;
    logic [23:0] ext_addr;
    logic [15:0] ext_wdata;
    logic busy;
    logic done;
    logic err;
  } unit_s;

endpackage : vec_unit_pkg

// ===== design/elem_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "vec_unit_regs.svh"

module elem_alu (
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  input wire logic [5:0] op_i,
  output logic [15:0] y_o
);

  // ========================================================================
  // Element operation
  always_comb begin
    unique case (op_i)
      `OP_ADD: y_o = 16'(a_i + b_i);
      `OP_SUB: y_o = 16'(a_i - b_i);
      `OP_AND_NOT: y_o = a_i & ~b_i;
      `OP_AND: y_o = a_i & b_i;
      `OP_OR: y_o = a_i | b_i;
      `OP_XOR: y_o = a_i ^ b_i;
      `OP_COMPLEMENT: y_o = ~b_i;
      default: y_o = 16'h0000;
    endcase
  end

endmodule : elem_alu
`default_nettype wire

// ===== design/cplx_mult.sv
`timescale 1ns/1ps
`default_nettype none

module cplx_mult (
  input wire logic [31:0] x_i,
  input wire logic [31:0] y_i,
  input wire logic conj_i,
  output logic [31:0] p_lo_o,
  output logic [31:0] p_hi_o,
  output logic [31:0] re_o,
  output logic [31:0] im_o
);

  logic signed [31:0] rr;
  logic signed [31:0] ii;
  logic signed [31:0] ir;
  logic signed [31:0] ri;

  // ========================================================================
  // Partial products, low half real, high half imaginary
  assign rr = $signed(x_i[15:0]) * $signed(y_i[15:0]);
  assign ii = $signed(x_i[31:16]) * $signed(y_i[31:16]);
  assign ir = $signed(x_i[31:16]) * $signed(y_i[15:0]);
  assign ri = $signed(x_i[15:0]) * $signed(y_i[31:16]);
  assign p_lo_o = rr;
  assign p_hi_o = ii;
  assign re_o = conj_i ? 32'(rr + ii) : 32'(rr - ii);
  assign im_o = conj_i ? 32'(ir - ri) : 32'(ir + ri);

endmodule : cplx_mult
`default_nettype wire

// ===== design/vector_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "vec_unit_regs.svh"

module vector_datapath
  import vec_unit_pkg::*;
#(
  parameter logic [10:0] PAIRED_ACC_FN = 11'h7FF // Arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic [15:0] element_count_param_i,
  input wire logic [5:0] operation_select_field_i,
  input wire logic accumulator_clear_flag_i,
  input wire logic subtract_select_flag_i,
  input wire logic conjugate_select_flag_i,
  input wire logic [15:0] x_addr_i,
  input wire logic [15:0] y_addr_i,
  input wire logic [15:0] z_addr_i,
  input wire logic [23:0] ext_base_i,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [15:0] ram_addr_o,
  output logic ram_rd_o,
  output logic ram_wr_o,
  output logic [1:0] ram_wen_o,
  output logic [31:0] ram_wdata_o,
  input wire logic [31:0] ram_rdata_i,
  output logic ext_req_o,
  output logic ext_we_o,
  output logic [23:0] ext_addr_o,
  output logic [15:0] ext_wdata_o,
  input wire logic ext_ack_i,
  input wire logic [15:0] ext_rdata_i
);

  // ========================================================================
  // Reset release
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ========================================================================
  // Helpers
  function automatic kind_e decode(input logic [10:0] f, input logic [10:0] pfn);
    if (f == pfn) begin
      decode = K_PMAC;
    end else begin
      unique case (f)
        `FN_COPY_REAL: decode = K_COPY;
        `FN_COPY_PAIRED: decode = K_PCOPY;
        `FN_INT_GATHER: decode = K_GATH;
        `FN_INT_SCATTER: decode = K_SCAT;
        `FN_EXT_LOAD: decode = K_XLD;
        `FN_EXT_STORE: decode = K_XST;
        `FN_EXT_GATHER: decode = K_XGA;
        `FN_ELEM_OP: decode = K_OP;
        `FN_PAIRED_OP: decode = K_POP;
        `FN_REAL_ACC: decode = K_RMAC;
        `FN_CPLX_ACC: decode = K_CMAC;
        `FN_REAL_LAT: decode = K_RLAT;
        `FN_CPLX_LAT: decode = K_CLAT;
        `FN_INT_MULADD: decode = K_IMAD;
        default: decode = K_NONE;
      endcase
    end
  endfunction : decode

  function automatic logic op_legal(input logic [5:0] o);
    op_legal = (o == `OP_ADD) || (o == `OP_SUB) || (o == `OP_AND_NOT) || (o == `OP_AND)
      || (o == `OP_OR) || (o == `OP_XOR) || (o == `OP_COMPLEMENT);
  endfunction : op_legal

  function automatic logic [15:0] elem_addr(input logic [15:0] b, input logic [15:0] i,
                                            input logic w);
    elem_addr = w ? 16'(b + {i[14:0], 1'b0}) : 16'(b + i);
  endfunction : elem_addr

  function automatic logic [23:0] ext_loc(input logic [23:0] b, input logic [15:0] a);
    ext_loc = 24'(b + {7'h00, a, 1'b0});
  endfunction : ext_loc

  function automatic state_e first_st(input kind_e k);
    if (k == K_GATH || k == K_XGA) begin
      first_st = ST_RY;
    end else if (k == K_XLD) begin
      first_st = ST_EXT;
    end else begin
      first_st = ST_RX;
    end
  endfunction : first_st

  // ========================================================================
  // State and arithmetic
  unit_s s;
  unit_s next_s;
  logic [1:0][15:0] alu_y;
  logic [31:0] p_lo;
  logic [31:0] p_hi;
  logic [31:0] p_re;
  logic [31:0] p_im;
  logic [31:0] add_re;
  logic [31:0] t_re;
  logic [31:0] t_im;
  logic [15:0] imad_lo;
  logic [15:0] imad_hi;
  logic wide;
  logic lat;
  logic [15:0] ix;
  logic [15:0] next_n;
  kind_e cmd_kind;

  generate
    for (genvar h = 0; h < 2; h++) begin : g_half
      elem_alu u_alu (
        .a_i(s.xd[16*h +: 16]),
        .b_i(s.yd[16*h +: 16]),
        .op_i(s.op),
        .y_o(alu_y[h])
      );
    end
  endgenerate

  cplx_mult u_mult (
    .x_i(s.xd),
    .y_i(s.yd),
    .conj_i(s.conj || s.kind == K_PMAC),
    .p_lo_o(p_lo),
    .p_hi_o(p_hi),
    .re_o(p_re),
    .im_o(p_im)
  );

  assign cmd_kind = decode(cmd_word_i[10:0], PAIRED_ACC_FN);
  assign add_re = (s.kind inside {K_CMAC, K_CLAT, K_PMAC}) ? p_re : p_lo;
  assign t_re = s.sub ? 32'(s.acc_re - add_re) : 32'(s.acc_re + add_re);
  assign t_im = s.sub ? 32'(s.acc_im - p_im) : 32'(s.acc_im + p_im);
  assign imad_lo = s.clr ? p_lo[15:0] : (s.sub ? 16'(s.zd[15:0] - p_lo[15:0])
    : 16'(s.zd[15:0] + p_lo[15:0]));
  assign imad_hi = s.clr ? p_hi[15:0] : (s.sub ? 16'(s.zd[31:16] - p_hi[15:0])
    : 16'(s.zd[31:16] + p_hi[15:0]));

  // ========================================================================
  // Sequencer
  always_comb begin
    next_s = s;
    next_s.ram_rd = 1'b0;
    next_s.ram_wr = 1'b0;
    next_s.done = 1'b0;
    next_n = 16'(s.n + 16'h0001);
    // Read data lands one cycle after its request
    next_s.rd_pend = s.ram_rd;
    next_s.rd_tgt = (s.st == ST_RY) ? 2'd1 : ((s.st == ST_RZ) ? 2'd2 : 2'd0);
    if (s.rd_pend) begin
      unique case (s.rd_tgt)
        2'd1: next_s.yd = ram_rdata_i;
        2'd2: next_s.zd = ram_rdata_i;
        default: next_s.xd = ram_rdata_i;
      endcase
    end
    unique case (s.st)
      ST_IDLE: begin
        next_s.err = 1'b0;
        if (cmd_valid_i) begin
          next_s.kind = cmd_kind;
          next_s.n = 16'h0000;
          next_s.cnt = element_count_param_i;
          next_s.xa = x_addr_i;
          next_s.ya = y_addr_i;
          next_s.za = z_addr_i;
          next_s.base = ext_base_i;
          next_s.op = operation_select_field_i;
          next_s.clr = accumulator_clear_flag_i;
          next_s.sub = subtract_select_flag_i;
          next_s.conj = conjugate_select_flag_i;
          next_s.ind = 1'b0;
          next_s.fin = 1'b0;
          next_s.seed = cmd_kind inside {K_RLAT, K_CLAT};
          if (cmd_word_i[`PREFIX_MSB:`PREFIX_LSB] != `EXECUTE_FORM_PREFIX_PREFIX || cmd_kind == K_NONE
              || (cmd_kind inside {K_OP, K_POP} && !op_legal(operation_select_field_i))) begin
            next_s.err = 1'b1;
            next_s.st = ST_DONE;
          end else if (cmd_kind inside {K_RMAC, K_PMAC, K_CMAC}) begin
            if (accumulator_clear_flag_i) begin
              next_s.acc_re = 32'h00000000;
              next_s.acc_im = 32'h00000000;
            end
            next_s.fin = (element_count_param_i == 16'h0000);
            next_s.st = next_s.fin ? ST_WR : ST_RX;
          end else if (next_s.seed) begin
            next_s.st = ST_RZ;
          end else if (element_count_param_i == 16'h0000) begin
            next_s.st = ST_DONE;
          end else begin
            next_s.st = first_st(cmd_kind);
          end
        end
      end
      ST_RX: begin
        next_s.st = (s.kind inside {K_COPY, K_PCOPY, K_XST}) ? ST_LAT : ST_RY;
      end
      ST_RY: begin
        next_s.st = (s.kind == K_IMAD) ? ST_RZ : ST_LAT;
      end
      ST_RZ: begin
        next_s.st = ST_LAT;
      end
      ST_RI: begin
        next_s.ind = 1'b1;
        next_s.st = ST_LAT;
      end
      ST_LAT: begin
        if (s.seed) begin
          next_s.seed = 1'b0;
          if (s.kind == K_RLAT) begin
            next_s.acc_re = {{2{next_s.zd[15]}}, next_s.zd[14:0], 15'h0000};
          end else begin
            next_s.acc_re = {{2{next_s.zd[15]}}, next_s.zd[14:0], 15'h0000};
            next_s.acc_im = {{2{next_s.zd[31]}}, next_s.zd[30:16], 15'h0000};
          end
          next_s.n = 16'h0001;
          next_s.st = (s.cnt > 16'h0001) ? ST_RX : ST_DONE;
        end else if (s.kind == K_GATH) begin
          next_s.st = s.ind ? ST_WR : ST_RI;
        end else if (s.kind inside {K_XST, K_XGA}) begin
          next_s.st = ST_EXT;
        end else if (s.kind inside {K_COPY, K_PCOPY, K_SCAT}) begin
          next_s.st = ST_WR;
        end else begin
          next_s.st = ST_ACC;
        end
      end
      ST_EXT: begin
        if (ext_ack_i) begin
          next_s.ext_req = 1'b0;
          next_s.xd = {16'h0000, ext_rdata_i};
          if (s.kind == K_XST) begin
            next_s.st = (next_n >= s.cnt) ? ST_DONE : first_st(s.kind);
            next_s.n = next_n;
          end else begin
            next_s.st = ST_WR;
          end
        end
      end
      ST_ACC: begin
        next_s.st = ST_WR;
        unique case (s.kind)
          K_RMAC, K_PMAC, K_CMAC: begin
            next_s.acc_re = t_re;
            next_s.acc_im = (s.kind == K_CMAC) ? t_im : s.acc_im;
            next_s.fin = (next_n >= s.cnt);
            next_s.st = next_s.fin ? ST_WR : ST_RX;
            next_s.n = next_s.fin ? s.n : next_n;
          end
          K_RLAT: begin
            next_s.zd = {16'h0000, t_re[`FRAC_MSB:`FRAC_LSB]};
            next_s.acc_re = {{2{t_re[`FRAC_MSB]}}, t_re[`FRAC_MSB-1:`FRAC_LSB], 15'h0000};
          end
          K_CLAT: begin
            next_s.zd = {t_im[`FRAC_MSB:`FRAC_LSB], t_re[`FRAC_MSB:`FRAC_LSB]};
            next_s.acc_re = t_re;
            next_s.acc_im = t_im;
          end
          K_IMAD: next_s.zd = {imad_hi, imad_lo};
          K_POP: next_s.zd = {alu_y[1], alu_y[0]};
          default: next_s.zd = {16'h0000, alu_y[0]};
        endcase
      end
      ST_WR: begin
        next_s.n = next_n;
        if (s.fin || next_n >= s.cnt) begin
          next_s.st = ST_DONE;
        end else begin
          next_s.st = first_st(s.kind);
          next_s.ind = 1'b0;
        end
      end
      ST_DONE: begin
        next_s.err = 1'b0;
        next_s.st = ST_IDLE;
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Element shape and index of the command being entered
    wide = next_s.kind inside {K_PCOPY, K_POP, K_PMAC, K_CMAC, K_CLAT, K_IMAD};
    lat = next_s.kind inside {K_RLAT, K_CLAT};
    ix = 16'(next_s.n - (lat ? 16'h0001 : 16'h0000));
    // Requests are registered on entry to their state
    if (next_s.st != s.st) begin
      unique case (next_s.st)
        ST_RX: begin
          next_s.ram_rd = 1'b1;
          next_s.ram_addr = elem_addr(next_s.xa, ix, wide);
        end
        ST_RY: begin
          next_s.ram_rd = 1'b1;
          next_s.ram_addr = elem_addr(next_s.ya, ix, wide);
        end
        ST_RZ: begin
          next_s.ram_rd = 1'b1;
          next_s.ram_addr = next_s.seed ? next_s.za : elem_addr(next_s.za, next_s.n, wide);
        end
        ST_RI: begin
          next_s.ram_rd = 1'b1;
          next_s.ram_addr = 16'(s.xa + next_s.yd[15:0]) & `ADDR_MASK;
        end
        ST_EXT: begin
          next_s.ext_req = 1'b1;
          next_s.ext_we = (next_s.kind == K_XST);
          next_s.ext_wdata = next_s.xd[15:0];
          unique case (next_s.kind)
            K_XST: next_s.ext_addr = ext_loc(next_s.base,
                     elem_addr(next_s.za, next_s.n, 1'b0));
            K_XGA: next_s.ext_addr = ext_loc(next_s.base,
                     16'(next_s.xa + next_s.yd[15:0]) & `ADDR_MASK);
            default: next_s.ext_addr = ext_loc(next_s.base,
                       elem_addr(next_s.xa, next_s.n, 1'b0));
          endcase
        end
        ST_WR: begin
          next_s.ram_wr = 1'b1;
          next_s.ram_wen = wide ? 2'b11 : 2'b01;
          next_s.ram_addr = elem_addr(s.za, s.n, wide);
          next_s.ram_wdata = next_s.zd;
          unique case (s.kind)
            K_COPY, K_GATH, K_XLD, K_XGA: next_s.ram_wdata = {16'h0000, next_s.xd[15:0]};
            K_PCOPY: next_s.ram_wdata = next_s.xd;
            K_SCAT: begin
              next_s.ram_addr = 16'(next_s.za + next_s.yd[15:0]) & `ADDR_MASK;
              next_s.ram_wdata = {16'h0000, next_s.xd[15:0]};
            end
            K_RMAC, K_PMAC: begin
              next_s.ram_addr = next_s.za;
              next_s.ram_wen = 2'b01;
              next_s.ram_wdata = {16'h0000, next_s.acc_re[`FRAC_MSB:`FRAC_LSB]};
            end
            K_CMAC: begin
              next_s.ram_addr = next_s.za;
              next_s.ram_wdata = {next_s.acc_im[`FRAC_MSB:`FRAC_LSB],
                                  next_s.acc_re[`FRAC_MSB:`FRAC_LSB]};
            end
            default: next_s.ram_wen = wide ? 2'b11 : 2'b01;
          endcase
        end
        default: next_s.ram_rd = 1'b0;
      endcase
    end
    next_s.done = (next_s.st == ST_DONE);
    next_s.busy = (next_s.st != ST_IDLE);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Outputs
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign err_o = s.err;
  assign ram_addr_o = s.ram_addr;
  assign ram_rd_o = s.ram_rd;
  assign ram_wr_o = s.ram_wr;
  assign ram_wen_o = s.ram_wen;
  assign ram_wdata_o = s.ram_wdata;
  assign ext_req_o = s.ext_req;
  assign ext_we_o = s.ext_we;
  assign ext_addr_o = s.ext_addr;
  assign ext_wdata_o = s.ext_wdata;

endmodule : vector_datapath
`default_nettype wire

// ===== sim/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Internal RAM and external memory
module mem_model (
  input wire logic clk_i,
  input wire logic [15:0] ram_addr_i,
  input wire logic ram_rd_i,
  input wire logic ram_wr_i,
  input wire logic [1:0] ram_wen_i,
  input wire logic [31:0] ram_wdata_i,
  output logic [31:0] ram_rdata_o,
  input wire logic ext_req_i,
  input wire logic ext_we_i,
  input wire logic [23:0] ext_addr_i,
  input wire logic [15:0] ext_wdata_i,
  output logic ext_ack_o,
  output logic [15:0] ext_rdata_o
);
  logic [15:0] mem [0:255];
  logic [15:0] xm [0:255];
  logic [2:0] wait_cnt = 3'h0;
  logic slow = 1'b0;
  initial begin
    ram_rdata_o = 32'h0;
    ext_ack_o = 1'b0;
    ext_rdata_o = 16'h0;
  end
  // Read data valid one cycle, scrambled otherwise
  always @(posedge clk_i) begin
    ram_rdata_o <= ram_rd_i ? {mem[ram_addr_i[7:0] + 8'h01], mem[ram_addr_i[7:0]]} : ~ram_rdata_o;
    if (ram_wr_i && ram_wen_i[0]) mem[ram_addr_i[7:0]] <= ram_wdata_i[15:0];
    if (ram_wr_i && ram_wen_i[1]) mem[ram_addr_i[7:0] + 8'h01] <= ram_wdata_i[31:16];
    ext_ack_o <= 1'b0;
    ext_rdata_o <= ~ext_rdata_o;
    // Prompt and slow answers alternate
    if (ext_req_i && !ext_ack_o) begin
      wait_cnt <= wait_cnt + 3'h1;
      if (wait_cnt == (slow ? 3'h3 : 3'h0)) begin
        ext_ack_o <= 1'b1;
        wait_cnt <= 3'h0;
        slow <= !slow;
        if (ext_we_i) xm[ext_addr_i[8:1]] <= ext_wdata_i;
        else ext_rdata_o <= xm[ext_addr_i[8:1]];
      end
    end
  end
endmodule : mem_model
`default_nettype wire

// ===== sim/vector_datapath_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "vec_unit_regs.svh"
// ====
// Port checks
module vector_datapath_props (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic [15:0] element_count_param_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic err_o,
  input wire logic ram_rd_o,
  input wire logic ram_wr_o,
  input wire logic ext_req_o,
  input wire logic ext_we_o,
  input wire logic [23:0] ext_addr_o,
  input wire logic ext_ack_i
);
  wire logic take = cmd_valid_i && !busy_o;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done too long");
  err_done_a: assert property (err_o |-> done_o)
    else $error("err without done");
  refuse_path_a: assert property (take && cmd_word_i[15:11] != `EXECUTE_FORM_PREFIX_PREFIX |=>
    busy_o && done_o && err_o && !ram_rd_o && !ram_wr_o && !ext_req_o)
    else $error("bad prefix not refused");
  copy_walk_a: assert property (take && cmd_word_i == {`EXECUTE_FORM_PREFIX_PREFIX, `FN_COPY_REAL} &&
    element_count_param_i != 16'h0000 |=> ram_rd_o ##2 ram_wr_o)
    else $error("copy element timing wrong");
  take_busy_a: assert property (take |=> busy_o)
    else $error("busy not raised");
  done_idle_a: assert property (done_o |-> busy_o ##1 !busy_o)
    else $error("busy not ending after done");
  rw_excl_a: assert property (!(ram_rd_o && ram_wr_o))
    else $error("read and write together");
  ext_hold_a: assert property (ext_req_o && !ext_ack_i |=>
    ext_req_o && $stable(ext_addr_o) && $stable(ext_we_o))
    else $error("ext request dropped early");
  ext_quiet_a: assert property (done_o || !busy_o |-> !ext_req_o)
    else $error("ext request open at done");
endmodule : vector_datapath_props
bind vector_datapath vector_datapath_props chk (.*);
`default_nettype wire

// ===== sim/vector_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vec_unit_regs.svh"
// ====
// Bench
module vector_datapath_tb;
  logic clk, rstn, cv, busy, done, err, rrd, rwr, xreq, xwe, xack, clr, sub, cj;
  logic [15:0] word, cnt, xa, raddr, xwd, xrd;
  logic [23:0] xad;
  logic [31:0] wd, rd, acc, acc2;
  logic [5:0] op;
  logic [4:0] pfx;
  logic [1:0] wen;
  logic [5:0] ops [7] = '{`OP_ADD, `OP_SUB, `OP_AND_NOT, `OP_AND, `OP_OR, `OP_XOR, `OP_COMPLEMENT};
  int err_count, num_checks;
  vector_datapath uut (.ref_clk_i(clk), .rstn_i(rstn), .cmd_valid_i(cv), .cmd_word_i(word),
    .element_count_param_i(cnt), .operation_select_field_i(op), .accumulator_clear_flag_i(clr),
    .subtract_select_flag_i(sub), .conjugate_select_flag_i(cj), .x_addr_i(xa),
    .y_addr_i(16'h0020), .z_addr_i(16'h0040), .ext_base_i(24'h020000), .busy_o(busy),
    .done_o(done), .err_o(err), .ram_addr_o(raddr), .ram_rd_o(rrd), .ram_wr_o(rwr),
    .ram_wen_o(wen), .ram_wdata_o(wd), .ram_rdata_i(rd), .ext_req_o(xreq), .ext_we_o(xwe),
    .ext_addr_o(xad), .ext_wdata_o(xwd), .ext_ack_i(xack), .ext_rdata_i(xrd));
  mem_model mm (.clk_i(clk), .ram_addr_i(raddr), .ram_rd_i(rrd), .ram_wr_i(rwr), .ram_wen_i(wen),
    .ram_wdata_i(wd), .ram_rdata_o(rd), .ext_req_i(xreq), .ext_we_i(xwe), .ext_addr_i(xad),
    .ext_wdata_i(xwd), .ext_ack_o(xack), .ext_rdata_o(xrd));
  // ====
  // Helpers
  function automatic logic [15:0] f(input int a);
    return {8'(a) ^ 8'h35, 8'(a)};
  endfunction : f
  function automatic logic [31:0] mul(input logic [15:0] a, input logic [15:0] b);
    return {{16{a[15]}}, a} * {{16{b[15]}}, b};
  endfunction : mul
  function automatic logic [15:0] opf(input logic [5:0] o, input logic [15:0] a, b);
    case (o)
      `OP_ADD: return a + b;
      `OP_SUB: return a - b;
      `OP_AND_NOT: return a & ~b;
      `OP_AND: return a & b;
      `OP_OR: return a | b;
      `OP_XOR: return a ^ b;
      default: return ~b;
    endcase
  endfunction : opf
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Fresh memories, one command, wait for done
  task automatic run(input logic [10:0] fn, input int c, input logic [5:0] o = 6'h00,
                     input logic [2:0] fl = 3'b000, input logic e = 1'b0);
    int k;
    for (int i = 0; i < 256; i++) begin
      mm.mem[i] = f(i);
      mm.xm[i] = ~f(i);
    end
    word = {pfx, fn};
    cnt = 16'(c);
    op = o;
    {clr, sub, cj} = fl;
    cv = 1'b1;
    @(posedge clk);
    #1 cv = 1'b0;
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 400) begin
      err_count++;
      tally_and_finish();
    end
    chk(16'(err), 16'(e));
    @(posedge clk);
    #1 $display("command %h finished", word);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====
  // Tests
  initial begin
    {rstn, cv, clr, sub, cj, word, cnt, op, err_count, num_checks} = '0;
    pfx = `EXECUTE_FORM_PREFIX_PREFIX;
    xa = 16'h0010;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    run(`FN_COPY_REAL, 3);
    for (int n = 0; n < 4; n++) chk(mm.mem[8'h40 + n], f(n < 3 ? 16 + n : 64 + n));
    run(`FN_COPY_PAIRED, 2);
    for (int n = 0; n < 4; n++) chk(mm.mem[8'h40 + n], f(16 + n));
    xa = 16'hFFF0;
    run(`FN_INT_GATHER, 2);
    for (int n = 0; n < 2; n++) chk(mm.mem[8'h40 + n], f(16'hFFF0 + f(32 + n)));
    xa = 16'h0010;
    run(`FN_INT_SCATTER, 2);
    for (int n = 0; n < 2; n++) chk(mm.mem[8'(64 + f(32 + n))], f(16 + n));
    run(`FN_EXT_LOAD, 2);
    for (int n = 0; n < 2; n++) chk(mm.mem[8'h40 + n], ~f(16 + n));
    run(`FN_EXT_STORE, 2);
    for (int n = 0; n < 2; n++) chk(mm.xm[8'h40 + n], f(16 + n));
    run(`FN_EXT_GATHER, 2);
    for (int n = 0; n < 2; n++) chk(mm.mem[8'h40 + n], ~f(16 + f(32 + n)));
    for (int i = 0; i < 7; i++) begin
      run(`FN_ELEM_OP, 1, ops[i]);
      chk(mm.mem[8'h40], opf(ops[i], f(16), f(32)));
    end
    run(`FN_ELEM_OP, 1, 6'h3F, 3'b000, 1'b1);
    chk(mm.mem[8'h40], f(64));
    run(`FN_PAIRED_OP, 1, `OP_SUB);
    for (int n = 0; n < 2; n++) chk(mm.mem[8'h40 + n], f(16 + n) - f(32 + n));
    acc = mul(f(16), f(32)) + mul(f(17), f(33));
    run(`FN_REAL_ACC, 2, 6'h00, 3'b100);
    chk(mm.mem[8'h40], acc[30:15]);
    acc = acc - mul(f(16), f(32));
    run(`FN_REAL_ACC, 1, 6'h00, 3'b010);
    chk(mm.mem[8'h40], acc[30:15]);
    acc = mul(f(16), f(32)) + mul(f(17), f(33));
    acc2 = mul(f(17), f(32)) - mul(f(16), f(33));
    run(`FN_CPLX_ACC, 1, 6'h00, 3'b101);
    chk(mm.mem[8'h40], acc[30:15]);
    chk(mm.mem[8'h41], acc2[30:15]);
    run(uut.PAIRED_ACC_FN, 1, 6'h00, 3'b100);
    chk(mm.mem[8'h40], acc[30:15]);
    acc = (32'($signed(f(64))) << 15) + mul(f(16), f(32));
    run(`FN_REAL_LAT, 2);
    chk(mm.mem[8'h41], acc[30:15]);
    acc = (32'($signed(f(64))) << 15) + mul(f(16), f(32)) - mul(f(17), f(33));
    acc2 = (32'($signed(f(65))) << 15) + mul(f(17), f(32)) + mul(f(16), f(33));
    run(`FN_CPLX_LAT, 2);
    chk(mm.mem[8'h42], acc[30:15]);
    chk(mm.mem[8'h43], acc2[30:15]);
    acc = mul(f(16), f(32));
    acc2 = mul(f(17), f(33));
    run(`FN_INT_MULADD, 1, 6'h00, 3'b010);
    chk(mm.mem[8'h40], f(64) - acc[15:0]);
    chk(mm.mem[8'h41], f(65) - acc2[15:0]);
    run(`FN_INT_MULADD, 1, 6'h00, 3'b100);
    chk(mm.mem[8'h40], acc[15:0]);
    pfx = 5'h00;
    run(`FN_COPY_REAL, 1, 6'h00, 3'b000, 1'b1);
    chk(mm.mem[8'h40], f(64));
    tally_and_finish();
  end
endmodule : vector_datapath_tb
`default_nettype wire
